// ### verilog/fas_defines.svh
// Purpose: Constants for the flash algorithm status block.
// Assumes: Included by the package and the design.
// Notes: Bit positions of the 16-bit status word and command codes.
`ifndef FAS_DEFINES_SVH
`define FAS_DEFINES_SVH
`define FAS_W 16
`define FAS_BIT_CRCS 8
`define FAS_BIT_RDY 7
`define FAS_BIT_ESUS 6
`define FAS_BIT_EFAIL 5
`define FAS_BIT_PFAIL 4
`define FAS_BIT_ABORT 3
`define FAS_BIT_PSUS 2
`define FAS_BIT_LOCK 1
`define FAS_BIT_SECTOR_ERASE_RESULT_FLAG 0
`define FAS_RESET_WORD 16'h0080
`define FAS_CMD_W 4
`define FAS_CMD_NONE 4'h0
`define FAS_CMD_STATUS_READ 4'h1
`define FAS_CMD_CLEAR_STATUS 4'h2
`define FAS_CMD_SOFT_RESET 4'h3
`define FAS_CMD_ERASE 4'h4
`define FAS_CMD_PROGRAM 4'h5
`define FAS_CMD_ERASE_SUSPEND 4'h6
`define FAS_CMD_ERASE_RESUME 4'h7
`define FAS_CMD_PROG_SUSPEND 4'h8
`define FAS_CMD_PROG_RESUME 4'h9
`define FAS_CMD_CRC 4'hA
`define FAS_CMD_CRC_SUSPEND 4'hB
`define FAS_CMD_CRC_RESUME 4'hC
`define FAS_CMD_BUF_ABORT 4'hD
`define FAS_OP_CYCLES 8'h10
`endif

// ### verilog/fas_pkg.sv
// Purpose: Types for the flash algorithm status block.
// Assumes: fas_defines.svh supplies widths and codes.
// Notes: Algorithm controller states.
`default_nettype none
`include "fas_defines.svh"
package fas_pkg;
    typedef logic [`FAS_CMD_W-1:0] fas_cmd_t;
    typedef logic [`FAS_W-1:0] fas_word_t;
    typedef enum logic [2:0] {
        FAS_IDLE,
        FAS_ERASING,
        FAS_PROGRAMMING,
        FAS_CRC_RUN,
        FAS_ERASE_SUSP,
        FAS_PROG_SUSP,
        FAS_CRC_SUSP
    } fas_state_t;
endpackage : fas_pkg
`default_nettype wire

// ### verilog/fas_status.sv
// Purpose: Status word and embedded algorithm tracking of a flash device.
// Assumes: Commands arrive as one-cycle strobes with a code; reads as one-cycle strobes.
// Notes: Array operations are modelled by a fixed-length busy counter.
// Summary of operation
// - Status-read command, then one read returns status
// - That read returns status at any address
// - Overlay exits after that single read
// - Bit 7 ready high when idle
// - Other bits valid only while ready
// - Clear/soft reset zero bits 5,4,3,1,0
// - Cold or warm reset loads 0x80
// - Bit 6 set during erase suspend, resume clears
// - Bit 2 set during program suspend, resume clears
// - Bit 8 in CRC suspend, only reads and CRC resume accepted
// - Bit 5 reports last erase failure
// - Bit 4 reports last program failure
// - Bit 3 set on buffer program abort
// - Bit 1 set on protected target failure
// - Bit 0 set on successful erase
// - Program to suspended sector fails
// - Erase during erase suspend fails
// - Program during program suspend fails
// - Erase during program suspend fails
// - During erase only status read, suspend accepted
`default_nettype none
`include "fas_defines.svh"
module fas_status (
    input wire logic CLK_SYS,
    input wire logic ARST_N,
    input wire logic WARM_RESET_N,
    input wire logic CMD_STROBE,
    input wire fas_pkg::fas_cmd_t CMD_CODE,
    input wire logic CMD_TARGET_LOCKED,
    input wire logic CMD_TARGET_SUSPENDED,
    input wire logic CMD_FAIL,
    input wire logic READ_STROBE,
    input wire fas_pkg::fas_word_t ARRAY_DATA,
    output logic [`FAS_W-1:0] READ_DATA,
    output logic READ_VALID,
    output logic OVERLAY_MODE,
    output logic DEVICE_READY
);
    import fas_pkg::*;

    fas_state_t state_reg, state_next;
    logic [7:0] busy_cnt_reg;
    logic overlay_reg;
    logic efail_reg, pfail_reg, abort_reg, lock_reg, sector_erase_result_flag_reg;
    logic warm_s1_reg, warm_s2_reg;
    logic fail_pend_reg;
    logic [`FAS_W-1:0] rdata_reg;
    logic rvalid_reg;

    // Warm reset arrives from a pin
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            warm_s1_reg <= 1'b1;
            warm_s2_reg <= 1'b1;
        end else begin
            warm_s1_reg <= WARM_RESET_N;
            warm_s2_reg <= warm_s1_reg;
        end
    end
    wire warm_rst = !warm_s2_reg;

    wire is_cmd = CMD_STROBE;
    wire c_sread = is_cmd && CMD_CODE == `FAS_CMD_STATUS_READ;
    wire c_erase = is_cmd && CMD_CODE == `FAS_CMD_ERASE;
    wire c_prog = is_cmd && CMD_CODE == `FAS_CMD_PROGRAM;
    wire c_abort = is_cmd && CMD_CODE == `FAS_CMD_BUF_ABORT;
    wire busy_done = busy_cnt_reg == 8'h01;

    wire st_idle = state_reg == FAS_IDLE;
    wire st_esus = state_reg == FAS_ERASE_SUSP;
    wire st_psus = state_reg == FAS_PROG_SUSP;
    wire st_csus = state_reg == FAS_CRC_SUSP;
    wire st_busy = state_reg == FAS_ERASING || state_reg == FAS_PROGRAMMING
                   || state_reg == FAS_CRC_RUN;
    // CRC suspend admits only array reads, status reads and the CRC resume command
    wire cmd_ok = !st_csus || c_sread
                  || (is_cmd && CMD_CODE == `FAS_CMD_CRC_RESUME);
    // Clear is ignored while an algorithm runs, else live results could be wiped
    wire c_clear = is_cmd && cmd_ok && !st_busy && (CMD_CODE == `FAS_CMD_CLEAR_STATUS
                   || CMD_CODE == `FAS_CMD_SOFT_RESET);

    // Program commands accepted while idle or erase-suspended start an operation
    wire can_start = (st_idle || st_esus) && cmd_ok;
    wire erase_bad = c_erase && (st_esus || st_psus);
    wire prog_bad = c_prog && (st_psus || (st_esus && CMD_TARGET_SUSPENDED));
    wire erase_go = c_erase && st_idle && !CMD_TARGET_LOCKED;
    wire erase_lock = c_erase && st_idle && CMD_TARGET_LOCKED;
    wire prog_go = c_prog && can_start && !prog_bad && !CMD_TARGET_LOCKED;
    wire prog_lock = c_prog && can_start && !prog_bad && CMD_TARGET_LOCKED;

    // Return state after an erase-suspended program finishes
    logic ret_esus_reg;
    // Suspended erase's remaining time and outcome, parked during its program
    logic [7:0] esus_cnt_reg;
    logic esus_fail_reg;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            FAS_IDLE: begin
                if (erase_go) state_next = FAS_ERASING;
                else if (prog_go) state_next = FAS_PROGRAMMING;
                else if (is_cmd && CMD_CODE == `FAS_CMD_CRC) state_next = FAS_CRC_RUN;
            end
            FAS_ERASING: begin
                // Only suspend honoured here; status read handled by overlay
                if (is_cmd && CMD_CODE == `FAS_CMD_ERASE_SUSPEND)
                    state_next = FAS_ERASE_SUSP;
                else if (busy_done) state_next = FAS_IDLE;
            end
            FAS_PROGRAMMING: begin
                if (is_cmd && CMD_CODE == `FAS_CMD_PROG_SUSPEND && !ret_esus_reg)
                    state_next = FAS_PROG_SUSP;
                else if (busy_done) state_next = ret_esus_reg ? FAS_ERASE_SUSP : FAS_IDLE;
            end
            FAS_CRC_RUN: begin
                if (is_cmd && CMD_CODE == `FAS_CMD_CRC_SUSPEND) state_next = FAS_CRC_SUSP;
                else if (busy_done) state_next = FAS_IDLE;
            end
            FAS_ERASE_SUSP: begin
                if (is_cmd && CMD_CODE == `FAS_CMD_ERASE_RESUME) state_next = FAS_ERASING;
                else if (prog_go) state_next = FAS_PROGRAMMING;
            end
            FAS_PROG_SUSP: begin
                if (is_cmd && CMD_CODE == `FAS_CMD_PROG_RESUME) state_next = FAS_PROGRAMMING;
            end
            FAS_CRC_SUSP: begin
                if (is_cmd && CMD_CODE == `FAS_CMD_CRC_RESUME) state_next = FAS_CRC_RUN;
            end
            default: state_next = FAS_IDLE;
        endcase
    end

    wire entering_run = state_next != state_reg
                        && (state_next == FAS_ERASING || state_next == FAS_PROGRAMMING
                            || state_next == FAS_CRC_RUN);
    // A suspend on the last busy cycle must not count as completion
    wire finishing = st_busy && busy_done && (state_next == FAS_IDLE || ret_esus_reg);
    wire run_next = state_next == FAS_ERASING || state_next == FAS_PROGRAMMING
                    || state_next == FAS_CRC_RUN;
    wire start_op = prog_go || (entering_run && busy_cnt_reg == 8'h00);
    logic ready_reg;

    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            state_reg <= FAS_IDLE;
            busy_cnt_reg <= 8'h00;
            ret_esus_reg <= 1'b0;
            fail_pend_reg <= 1'b0;
            esus_cnt_reg <= 8'h00;
            esus_fail_reg <= 1'b0;
        end else if (warm_rst) begin
            state_reg <= FAS_IDLE;
            busy_cnt_reg <= 8'h00;
            ret_esus_reg <= 1'b0;
            fail_pend_reg <= 1'b0;
            esus_cnt_reg <= 8'h00;
            esus_fail_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            if (start_op) busy_cnt_reg <= `FAS_OP_CYCLES;
            else if (st_busy && busy_cnt_reg != 8'h00 && state_next == state_reg)
                busy_cnt_reg <= busy_cnt_reg - 8'h01;
            else if (finishing) busy_cnt_reg <= ret_esus_reg ? esus_cnt_reg : 8'h00;
            if (prog_go) ret_esus_reg <= st_esus;
            else if (finishing) ret_esus_reg <= 1'b0;
            if (start_op) fail_pend_reg <= CMD_FAIL;
            else if (finishing && ret_esus_reg) fail_pend_reg <= esus_fail_reg;
            if (prog_go && st_esus) begin
                esus_cnt_reg <= busy_cnt_reg;
                esus_fail_reg <= fail_pend_reg;
            end
        end
    end

    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            ready_reg <= 1'b1;
        end else if (warm_rst) begin
            ready_reg <= 1'b1;
        end else begin
            ready_reg <= !run_next;
        end
    end

    // Result flags: events win over a clear in the same cycle
    wire erase_end = state_reg == FAS_ERASING && finishing;
    wire prog_end = state_reg == FAS_PROGRAMMING && finishing;
    wire efail_set = erase_bad || erase_lock || (erase_end && fail_pend_reg);
    wire efail_clr = c_clear || erase_go;
    wire pfail_set = prog_bad || prog_lock || (prog_end && fail_pend_reg);
    wire pfail_clr = c_clear || prog_go;
    wire lock_set = erase_lock || prog_lock;
    wire lock_clr = c_clear || erase_go || prog_go;
    wire abort_set = c_abort && (st_idle || st_esus);
    wire sector_erase_result_flag_set = erase_end && !fail_pend_reg;
    wire sector_erase_result_flag_clr = c_clear || erase_go || erase_lock || erase_bad;

    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            efail_reg <= 1'b0;
            pfail_reg <= 1'b0;
            abort_reg <= 1'b0;
            lock_reg <= 1'b0;
            sector_erase_result_flag_reg <= 1'b0;
        end else if (warm_rst) begin
            efail_reg <= 1'b0;
            pfail_reg <= 1'b0;
            abort_reg <= 1'b0;
            lock_reg <= 1'b0;
            sector_erase_result_flag_reg <= 1'b0;
        end else begin
            efail_reg <= efail_set || (efail_reg && !efail_clr);
            pfail_reg <= pfail_set || (pfail_reg && !pfail_clr);
            abort_reg <= abort_set || (abort_reg && !c_clear && !prog_go);
            lock_reg <= lock_set || (lock_reg && !lock_clr);
            sector_erase_result_flag_reg <= sector_erase_result_flag_set || (sector_erase_result_flag_reg && !sector_erase_result_flag_clr);
        end
    end

    // Reserved bits read as zero
    wire ready = !st_busy;
    wire [`FAS_W-1:0] status_word = {7'h00, st_csus, ready, st_esus, efail_reg, pfail_reg,
                                    abort_reg, st_psus, lock_reg, sector_erase_result_flag_reg};

    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            overlay_reg <= 1'b0;
            rdata_reg <= `FAS_RESET_WORD;
            rvalid_reg <= 1'b0;
        end else if (warm_rst) begin
            overlay_reg <= 1'b0;
            rdata_reg <= `FAS_RESET_WORD;
            rvalid_reg <= 1'b0;
        end else begin
            rvalid_reg <= READ_STROBE;
            if (READ_STROBE) begin
                rdata_reg <= overlay_reg ? status_word : ARRAY_DATA;
                overlay_reg <= 1'b0;
            end else if (c_sread) begin
                overlay_reg <= 1'b1;
            end
        end
    end

    assign READ_DATA = rdata_reg;
    assign READ_VALID = rvalid_reg;
    assign OVERLAY_MODE = overlay_reg;
    assign DEVICE_READY = ready_reg;

    property p_overlay_one_read;
        @(posedge CLK_SYS) disable iff (!ARST_N || warm_rst)
        overlay_reg && READ_STROBE |=> !overlay_reg && READ_VALID;
    endproperty
    a_overlay_one_read: assert property (p_overlay_one_read)
        else $error("overlay not left after read");

    property p_status_returned;
        @(posedge CLK_SYS) disable iff (!ARST_N || warm_rst)
        overlay_reg && READ_STROBE |=> READ_DATA == $past(status_word);
    endproperty
    a_status_returned: assert property (p_status_returned)
        else $error("status word not returned");

    property p_array_read;
        @(posedge CLK_SYS) disable iff (!ARST_N || warm_rst)
        !overlay_reg && READ_STROBE |=> READ_DATA == $past(ARRAY_DATA);
    endproperty
    a_array_read: assert property (p_array_read)
        else $error("array data not returned");

    property p_clear;
        @(posedge CLK_SYS) disable iff (!ARST_N || warm_rst)
        c_clear && !efail_set && !pfail_set && !lock_set && !abort_set && !sector_erase_result_flag_set
        |=> !efail_reg && !pfail_reg && !lock_reg && !abort_reg && !sector_erase_result_flag_reg;
    endproperty
    a_clear: assert property (p_clear)
        else $error("clear left result bits");

    property p_erase_in_susp;
        @(posedge CLK_SYS) disable iff (!ARST_N || warm_rst)
        c_erase && (st_esus || st_psus) |=> efail_reg && $stable(state_reg);
    endproperty
    a_erase_in_susp: assert property (p_erase_in_susp)
        else $error("erase in suspend did not fail");

    property p_prog_in_psus;
        @(posedge CLK_SYS) disable iff (!ARST_N || warm_rst)
        c_prog && st_psus |=> pfail_reg && state_reg == FAS_PROG_SUSP;
    endproperty
    a_prog_in_psus: assert property (p_prog_in_psus)
        else $error("program in program suspend did not fail");

    property p_prog_susp_sector;
        @(posedge CLK_SYS) disable iff (!ARST_N || warm_rst)
        c_prog && st_esus && CMD_TARGET_SUSPENDED |=> pfail_reg ##1 st_esus;
    endproperty
    a_prog_susp_sector: assert property (p_prog_susp_sector)
        else $error("program to suspended sector did not fail");

    property p_erase_ignores;
        @(posedge CLK_SYS) disable iff (!ARST_N || warm_rst)
        state_reg == FAS_ERASING && is_cmd && CMD_CODE == `FAS_CMD_PROGRAM && !busy_done
        |=> state_reg == FAS_ERASING;
    endproperty
    a_erase_ignores: assert property (p_erase_ignores)
        else $error("command accepted during erase");

    property p_ready_bit;
        @(posedge CLK_SYS) disable iff (!ARST_N || warm_rst)
        erase_go |=> !DEVICE_READY;
    endproperty
    a_ready_bit: assert property (p_ready_bit)
        else $error("ready during erase");

    property p_ready_level;
        @(posedge CLK_SYS) disable iff (!ARST_N || warm_rst)
        DEVICE_READY == !st_busy;
    endproperty
    a_ready_level: assert property (p_ready_level)
        else $error("ready pin disagrees with state");

    property p_lock_set;
        @(posedge CLK_SYS) disable iff (!ARST_N || warm_rst)
        (c_erase || c_prog) && CMD_TARGET_LOCKED && st_idle |=> lock_reg;
    endproperty
    a_lock_set: assert property (p_lock_set)
        else $error("locked target not flagged");

    property p_erase_result;
        @(posedge CLK_SYS) disable iff (!ARST_N || warm_rst)
        erase_end |=> sector_erase_result_flag_reg != $past(fail_pend_reg);
    endproperty
    a_erase_result: assert property (p_erase_result)
        else $error("erase result bit wrong");

    property p_erase_resume;
        @(posedge CLK_SYS) disable iff (!ARST_N || warm_rst)
        st_esus && is_cmd && CMD_CODE == `FAS_CMD_ERASE_RESUME |=> !st_esus && !DEVICE_READY;
    endproperty
    a_erase_resume: assert property (p_erase_resume)
        else $error("erase resume not taken");

    property p_crc_refuse;
        @(posedge CLK_SYS) disable iff (!ARST_N || warm_rst)
        st_csus && is_cmd && CMD_CODE != `FAS_CMD_CRC_RESUME
        |=> st_csus && $stable({efail_reg, pfail_reg, abort_reg, lock_reg, sector_erase_result_flag_reg});
    endproperty
    a_crc_refuse: assert property (p_crc_refuse)
        else $error("command acted on during crc suspend");
endmodule : fas_status
`default_nettype wire

// ### tb/fas_host_model.sv
// Purpose: Host bus controller model issuing commands and reads.
// Assumes: Strobes driven at the rising edge, held through the taking edge.
// Notes: Reserved status bits are masked before anything is judged.
`default_nettype none
`include "fas_defines.svh"
module fas_host_model (
    input wire logic clk_sys,
    output logic cmd_strobe,
    output fas_pkg::fas_cmd_t cmd_code,
    output logic cmd_target_locked,
    output logic cmd_target_suspended,
    output logic cmd_fail,
    output logic read_strobe,
    output fas_pkg::fas_word_t array_data,
    input wire logic [`FAS_W-1:0] read_data,
    input wire logic read_valid
);
    timeunit 1ns;
    timeprecision 1ns;
    import fas_pkg::*;

    initial begin
        cmd_strobe = 1'b0;
        cmd_code = `FAS_CMD_NONE;
        {cmd_target_locked, cmd_target_suspended, cmd_fail} = 3'b000;
        read_strobe = 1'b0;
        array_data = 16'h0000;
    end

    task automatic cmd(input fas_cmd_t code, input logic [2:0] flags);
        @(posedge clk_sys);
        cmd_strobe <= 1'b1;
        cmd_code <= code;
        {cmd_target_locked, cmd_target_suspended, cmd_fail} <= flags;
        @(posedge clk_sys);
        cmd_strobe <= 1'b0;
        cmd_code <= `FAS_CMD_NONE;
    endtask : cmd

    task automatic rd(input fas_word_t value, output fas_word_t data, output logic valid);
        @(posedge clk_sys);
        read_strobe <= 1'b1;
        array_data <= value;
        @(posedge clk_sys);
        read_strobe <= 1'b0;
        // Array lines no longer hold the old word
        array_data <= ~value;
        @(negedge clk_sys);
        data = read_data;
        valid = read_valid;
    endtask : rd

    task automatic status(output fas_word_t data, output logic valid);
        cmd(`FAS_CMD_STATUS_READ, 3'b000);
        rd(16'hA5C3, data, valid);
        data = data & 16'h01FF;
    endtask : status

    // Suspended state is trusted only once ready reads back high
    task automatic poll(output fas_word_t data);
        logic valid;
        for (int i = 0; i < 40; i++) begin
            status(data, valid);
            if (data[`FAS_BIT_RDY] === 1'b1) break;
        end
    endtask : poll
endmodule : fas_host_model
`default_nettype wire

// ### tb/flash_algorithm_status_register_tb_top.sv
// Purpose: Self-checking bench for the algorithm status word.
// Assumes: Host model drives all command and read inputs.
// Notes: Expected words built from bit positions of the status word.
`default_nettype none
`include "fas_defines.svh"
module flash_algorithm_status_register_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import fas_pkg::*;

    logic clk_sys, arst_n, warm_reset_n, cmd_strobe, cmd_locked, cmd_susp, cmd_fail;
    logic read_strobe, read_valid, overlay_mode, device_ready, v;
    fas_cmd_t cmd_code;
    fas_word_t array_data, read_data, w;
    int miscompares = 0;
    int compares = 0;
    int cycles = 0;

    fas_status i_fas_status (.CLK_SYS(clk_sys), .ARST_N(arst_n), .WARM_RESET_N(warm_reset_n),
        .CMD_STROBE(cmd_strobe), .CMD_CODE(cmd_code), .CMD_TARGET_LOCKED(cmd_locked),
        .CMD_TARGET_SUSPENDED(cmd_susp), .CMD_FAIL(cmd_fail), .READ_STROBE(read_strobe),
        .ARRAY_DATA(array_data), .READ_DATA(read_data), .READ_VALID(read_valid),
        .OVERLAY_MODE(overlay_mode), .DEVICE_READY(device_ready));

    fas_host_model i_fas_host_model (.clk_sys(clk_sys), .cmd_strobe(cmd_strobe),
        .cmd_code(cmd_code), .cmd_target_locked(cmd_locked), .cmd_target_suspended(cmd_susp),
        .cmd_fail(cmd_fail), .read_strobe(read_strobe), .array_data(array_data),
        .read_data(read_data), .read_valid(read_valid));

    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    task automatic check(input string name, input fas_word_t seen, input fas_word_t exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic end_sim();
        $display("Counts: compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_sim

    // Whole run needs well under this many cycles
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 4000) begin
            miscompares++;
            $display("BAD timeout expected finish seen hang");
            end_sim();
        end
    end

    task automatic c(input fas_cmd_t code, input logic [2:0] flags = 3'b000);
        i_fas_host_model.cmd(code, flags);
    endtask : c

    task automatic st(input string name, input fas_word_t exp);
        i_fas_host_model.status(w, v);
        check({name, " valid"}, {15'h0000, v}, 16'h0001);
        check(name, w, exp);
    endtask : st

    task automatic pl(input string name, input fas_word_t exp);
        i_fas_host_model.poll(w);
        check(name, w, exp);
    endtask : pl

    initial begin
        arst_n = 1'b0;
        warm_reset_n = 1'b1;
        repeat (2) @(posedge clk_sys);
        arst_n <= 1'b1;
        st("reset word", 16'h0080);
        c(`FAS_CMD_STATUS_READ);
        @(negedge clk_sys);
        check("overlay set", {15'h0000, overlay_mode}, 16'h0001);
        i_fas_host_model.rd(16'h3C3C, w, v);
        check("overlay word", w & 16'h01FF, 16'h0080);
        check("overlay left", {15'h0000, overlay_mode}, 16'h0000);
        i_fas_host_model.rd(16'h5A5A, w, v);
        check("array read", w, 16'h5A5A);
        $display("test reset and overlay done");
        c(`FAS_CMD_ERASE);
        @(negedge clk_sys);
        check("ready pin", {15'h0000, device_ready}, 16'h0000);
        i_fas_host_model.status(w, v);
        check("busy bit", w & 16'h0080, 16'h0000);
        c(`FAS_CMD_PROGRAM, 3'b001);
        pl("erase ok", 16'h0081);
        c(`FAS_CMD_ERASE, 3'b001);
        pl("erase fail", 16'h00A0);
        c(`FAS_CMD_CLEAR_STATUS);
        st("cleared", 16'h0080);
        c(`FAS_CMD_PROGRAM, 3'b100);
        pl("locked", 16'h0092);
        c(`FAS_CMD_SOFT_RESET);
        st("soft reset", 16'h0080);
        c(`FAS_CMD_BUF_ABORT);
        st("abort", 16'h0088);
        c(`FAS_CMD_CLEAR_STATUS);
        $display("test results done");
        c(`FAS_CMD_ERASE);
        c(`FAS_CMD_ERASE_SUSPEND);
        pl("erase susp", 16'h00C0);
        c(`FAS_CMD_ERASE);
        pl("erase in esus", 16'h00E0);
        c(`FAS_CMD_PROGRAM, 3'b010);
        pl("prog susp sector", 16'h00F0);
        c(`FAS_CMD_CLEAR_STATUS);
        st("state kept", 16'h00C0);
        c(`FAS_CMD_ERASE_RESUME);
        pl("erase resumed", 16'h0081);
        c(`FAS_CMD_CLEAR_STATUS);
        $display("test erase suspend done");
        c(`FAS_CMD_PROGRAM);
        c(`FAS_CMD_PROG_SUSPEND);
        pl("prog susp", 16'h0084);
        c(`FAS_CMD_PROGRAM);
        pl("prog in psus", 16'h0094);
        c(`FAS_CMD_ERASE);
        pl("erase in psus", 16'h00B4);
        c(`FAS_CMD_CLEAR_STATUS);
        st("psus kept", 16'h0084);
        c(`FAS_CMD_PROG_RESUME);
        pl("prog resumed", 16'h0080);
        $display("test program suspend done");
        c(`FAS_CMD_CRC);
        c(`FAS_CMD_CRC_SUSPEND);
        pl("crc susp", 16'h0180);
        c(`FAS_CMD_ERASE);
        st("crc refuses", 16'h0180);
        c(`FAS_CMD_CRC_RESUME);
        pl("crc done", 16'h0080);
        c(`FAS_CMD_BUF_ABORT);
        @(posedge clk_sys);
        warm_reset_n <= 1'b0;
        repeat (3) @(posedge clk_sys);
        warm_reset_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        st("warm reset", 16'h0080);
        $display("test crc and warm reset done");
        end_sim();
    end
endmodule : flash_algorithm_status_register_tb_top
`default_nettype wire
